// [hw/edge_detect.sv]
`default_nettype none
module edge_detect
    import irq_ctrl_pkg::*;
(
    input  wire logic       mclk_i,  // system clock
    input  wire logic       rst_n_i, // sync reset, active low
    input  wire logic       ce_i,    // clock enable
    input  wire logic       pin_i,   // asynchronous pin
    input  wire logic [1:0] sel_i,   // edge select code
    output logic            hit_o    // selected edge seen, one pulse
);
    logic [2:0] sync_q;
    logic       level_q;
    logic       rise;
    logic       fall;

    // three-stage synchroniser, stage 0 only feeds stage 1
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            sync_q  <= 3'h0;
            level_q <= 1'b0;
        end else if (ce_i) begin
            sync_q <= {sync_q[1:0], pin_i};
            if (sync_q[1] == sync_q[2]) begin
                level_q <= sync_q[2];
            end
        end
    end

    // a change counts once stages one and two agree
    assign rise  = (sync_q[1] == sync_q[2]) && sync_q[2] && !level_q;
    assign fall  = (sync_q[1] == sync_q[2]) && !sync_q[2] && level_q;
    assign hit_o = ce_i && (((sel_i == EDGE_RISE) && rise) || ((sel_i == EDGE_FALL) && fall)
                 || ((sel_i == EDGE_BOTH) && (rise || fall)));
endmodule : edge_detect
`default_nettype wire

// [hw/mcu_interrupt_control.sv]
// What this block does
// - the pin edge field selects off, rising, falling or both edges for the pin flag.
// - bits 7..6 of the filter low-level register select the filtered input edge likewise.
// - bit 0 of control A is the global enable; at 0 nothing is taken.
// - control A holds the filtered, serial and pin flags in bits 6, 5 and 4.
// - control A holds the filtered, serial and pin enables in bits 3, 2 and 1.
// - control B holds group 2..0 flags in bits 6..4 and enables in bits 2..0.
// - control B holds the tick 0 flag in bit 7 and its enable in bit 3.
// - control C holds the tick 1 flag in bit 4 and enable in bit 0, other bits absent.
// - the compact timer register holds cmp A and P flags in 5, 4 and enables in 1, 0.
// - absent bits read zero and ignore writes.
// - flags and enables are read-write and clear at reset.
// - requests come from the pin, filtered input, timers, ticks, converter and serial.
// - a flag with its enable low stays set but requests no vector.
// - taking a vector clears the global enable; new flags still set.
// - no vector is taken while the return stack is full.
`default_nettype none
module mcu_interrupt_control
    import irq_ctrl_pkg::*;
(
    input  wire logic       mclk_i,            // system clock, 50 MHz
    input  wire logic       rst_n_i,           // sync reset, active low
    input  wire logic       ce_i,              // clock enable, freezes state
    input  wire logic [3:0] addr_i,            // register address
    input  wire logic [7:0] wdata_i,           // write data
    input  wire logic       wr_i,              // write strobe
    input  wire logic       rd_i,              // read strobe
    output logic      [7:0] rdata_o,           // read data, cycle after rd_i
    input  wire logic       int_pin_i,         // external interrupt pin
    input  wire logic       filtered_input_pin_i, // filtered input pin
    input  wire logic       serial_req_i,      // serial request pulse
    input  wire logic       tick0_req_i,       // time base 0 pulse
    input  wire logic       tick1_req_i,       // time base 1 pulse
    input  wire logic       ct_cmp_a_req_i,    // compact timer cmp A pulse
    input  wire logic       ct_cmp_p_req_i,    // compact timer cmp P pulse
    input  wire logic [1:0] grp1_req_i,        // group 1 sources a, p
    input  wire logic [2:0] grp2_req_i,        // group 2 converter, a, p
    input  wire logic       stack_full_i,      // return stack full
    input  wire logic       vec_ack_i,         // core takes the vector
    output logic            vec_req_o,         // vector request
    output logic      [2:0] vec_num_o,         // vector number
    output logic            irq_o              // status interrupt level
);
    logic [7:0] pin_edge_q;
    logic [7:0] ctrl_a_q;
    logic [7:0] ctrl_b_q;
    logic [7:0] ctrl_c_q;
    logic [7:0] ct_ctrl_q;
    logic [7:0] grp1_q;
    logic [7:0] grp2_q;
    logic [7:0] filt_low_q;
    logic [7:0] stat_q;
    logic [7:0] mask_q;
    logic [7:0] rdata_q;
    logic [7:0] ctrl_a_d;
    logic [7:0] ctrl_b_d;
    logic [7:0] ctrl_c_d;
    logic [7:0] ct_ctrl_d;
    logic [7:0] grp1_d;
    logic [7:0] grp2_d;
    logic [7:0] stat_d;
    logic       pin_hit;
    logic       flt_hit;
    logic [NUM_VEC-1:0] pend;
    logic [NUM_VEC-1:0] clr_vec;
    logic       any_pend;
    logic [2:0] vec_sel;
    logic       take;
    logic [7:0] rd_mux;

    // register write decode
    logic we_pin;
    logic we_a;
    logic we_b;
    logic we_c;
    logic we_ct;
    logic we_g1;
    logic we_g2;
    logic we_flt;
    logic we_mask;
    logic rd_stat;
    assign we_pin  = ce_i && wr_i && (addr_i == OFS_PIN_EDGE);
    assign we_a    = ce_i && wr_i && (addr_i == OFS_CTRL_A);
    assign we_b    = ce_i && wr_i && (addr_i == OFS_CTRL_B);
    assign we_c    = ce_i && wr_i && (addr_i == OFS_CTRL_C);
    assign we_ct   = ce_i && wr_i && (addr_i == OFS_CT_CTRL);
    assign we_g1   = ce_i && wr_i && (addr_i == OFS_GRP1);
    assign we_g2   = ce_i && wr_i && (addr_i == OFS_GRP2);
    assign we_flt  = ce_i && wr_i && (addr_i == OFS_FILT_LOW);
    assign we_mask = ce_i && wr_i && (addr_i == OFS_IRQ_MASK);
    assign rd_stat = ce_i && rd_i && (addr_i == OFS_IRQ_STAT);

    // pin edge detectors
    edge_detect u_pin_edge (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_n_i),
        .ce_i    (ce_i),
        .pin_i   (int_pin_i),
        .sel_i   (pin_edge_q[1:0]),
        .hit_o   (pin_hit)
    );
    edge_detect u_flt_edge (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_n_i),
        .ce_i    (ce_i),
        .pin_i   (filtered_input_pin_i),
        .sel_i   (filt_low_q[BIT_FLT_EDGE+1:BIT_FLT_EDGE]),
        .hit_o   (flt_hit)
    );

    // pending enabled requests in priority order; gated by enables
    assign pend[VEC_PIN]   = ctrl_a_q[BIT_PIN_F] && ctrl_a_q[BIT_PIN_E];
    assign pend[VEC_FLT]   = ctrl_a_q[BIT_FLT_F] && ctrl_a_q[BIT_FLT_E];
    assign pend[VEC_SER]   = ctrl_a_q[BIT_SER_F] && ctrl_a_q[BIT_SER_E];
    assign pend[VEC_TICK0] = ctrl_b_q[BIT_TICK0_F] && ctrl_b_q[BIT_TICK0_E];
    assign pend[VEC_TICK1] = ctrl_c_q[BIT_TICK1_F] && ctrl_c_q[BIT_TICK1_E];
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_grp
            assign pend[VEC_GRP0+g] = ctrl_b_q[BIT_GRP_F0+g] && ctrl_b_q[BIT_GRP_E0+g];
        end
    endgenerate

    prio_select #(.N(NUM_VEC)) u_prio (
        .req_i (pend),
        .any_o (any_pend),
        .vec_o (vec_sel)
    );

    // vector request needs global enable and room on the stack
    assign vec_req_o = ctrl_a_q[BIT_GIE] && any_pend && !stack_full_i;
    assign vec_num_o = vec_sel;
    assign take      = ce_i && vec_req_o && vec_ack_i;
    assign clr_vec   = take ? (NUM_VEC'(1) << vec_sel) : '0;

    // control A: software write, then hardware clear on take, then hardware set wins
    always_comb begin
        ctrl_a_d = we_a ? (wdata_i & MASK_CTRL_A) : ctrl_a_q;
        if (take) begin
            ctrl_a_d[BIT_GIE] = 1'b0;
        end
        if (clr_vec[VEC_PIN]) ctrl_a_d[BIT_PIN_F] = 1'b0;
        if (clr_vec[VEC_FLT]) ctrl_a_d[BIT_FLT_F] = 1'b0;
        if (clr_vec[VEC_SER]) ctrl_a_d[BIT_SER_F] = 1'b0;
        if (pin_hit) ctrl_a_d[BIT_PIN_F] = 1'b1;
        if (flt_hit) ctrl_a_d[BIT_FLT_F] = 1'b1;
        if (serial_req_i && ce_i) ctrl_a_d[BIT_SER_F] = 1'b1;
    end

    // group sub-registers; sources set, software writes
    always_comb begin
        ct_ctrl_d = we_ct ? (wdata_i & MASK_GRP) : ct_ctrl_q;
        grp1_d    = we_g1 ? (wdata_i & MASK_GRP) : grp1_q;
        grp2_d    = we_g2 ? (wdata_i & MASK_GRP) : grp2_q;
        if (ce_i && ct_cmp_p_req_i) ct_ctrl_d[BIT_SUB_F0]   = 1'b1;
        if (ce_i && ct_cmp_a_req_i) ct_ctrl_d[BIT_SUB_F0+1] = 1'b1;
        if (ce_i && grp1_req_i[0])  grp1_d[BIT_SUB_F0]      = 1'b1;
        if (ce_i && grp1_req_i[1])  grp1_d[BIT_SUB_F0+1]    = 1'b1;
        if (ce_i && grp2_req_i[0])  grp2_d[BIT_SUB_F0]      = 1'b1;
        if (ce_i && grp2_req_i[1])  grp2_d[BIT_SUB_F0+1]    = 1'b1;
    end

    // group summary: any enabled sub flag pending, or for group 2 the converter request
    logic [2:0] grp_sum;
    assign grp_sum[0] = |(ct_ctrl_q[5:4] & ct_ctrl_q[1:0]);
    assign grp_sum[1] = |(grp1_q[5:4] & grp1_q[1:0]);
    assign grp_sum[2] = |(grp2_q[5:4] & grp2_q[1:0]) || grp2_req_i[2];

    // control B and C
    always_comb begin
        ctrl_b_d = we_b ? (wdata_i & MASK_CTRL_B) : ctrl_b_q;
        ctrl_c_d = we_c ? (wdata_i & MASK_CTRL_C) : ctrl_c_q;
        if (clr_vec[VEC_GRP0]) ctrl_b_d[BIT_GRP_F0]   = 1'b0;
        if (clr_vec[VEC_GRP1]) ctrl_b_d[BIT_GRP_F0+1] = 1'b0;
        if (clr_vec[VEC_GRP2]) ctrl_b_d[BIT_GRP_F0+2] = 1'b0;
        if (clr_vec[VEC_TICK0]) ctrl_b_d[BIT_TICK0_F] = 1'b0;
        if (clr_vec[VEC_TICK1]) ctrl_c_d[BIT_TICK1_F] = 1'b0;
        if (ce_i && grp_sum[0]) ctrl_b_d[BIT_GRP_F0]   = 1'b1;
        if (ce_i && grp_sum[1]) ctrl_b_d[BIT_GRP_F0+1] = 1'b1;
        if (ce_i && grp_sum[2]) ctrl_b_d[BIT_GRP_F0+2] = 1'b1;
        if (ce_i && tick0_req_i) ctrl_b_d[BIT_TICK0_F] = 1'b1;
        if (ce_i && tick1_req_i) ctrl_c_d[BIT_TICK1_F] = 1'b1;
    end

    // status: bit 0 vector taken, 1 pin edge, 2 filtered edge, 3 refused by full stack
    always_comb begin
        stat_d = rd_stat ? RST_ZERO : stat_q;
        if (take) stat_d[0] = 1'b1;
        if (pin_hit) stat_d[1] = 1'b1;
        if (flt_hit) stat_d[2] = 1'b1;
        if (ce_i && stack_full_i && ctrl_a_q[BIT_GIE] && any_pend) stat_d[3] = 1'b1;
    end

    // register file update
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            pin_edge_q <= RST_ZERO;
            ctrl_a_q   <= RST_ZERO;
            ctrl_b_q   <= RST_ZERO;
            ctrl_c_q   <= RST_ZERO;
            ct_ctrl_q  <= RST_ZERO;
            grp1_q     <= RST_ZERO;
            grp2_q     <= RST_ZERO;
            filt_low_q <= RST_FILT_LOW;
            stat_q     <= RST_ZERO;
            mask_q     <= RST_ZERO;
        end else if (ce_i) begin
            if (we_pin) pin_edge_q <= wdata_i & MASK_PIN_EDGE;
            if (we_flt) filt_low_q <= wdata_i & MASK_FILT_LOW;
            if (we_mask) mask_q <= wdata_i & MASK_STAT;
            ctrl_a_q  <= ctrl_a_d;
            ctrl_b_q  <= ctrl_b_d;
            ctrl_c_q  <= ctrl_c_d;
            ct_ctrl_q <= ct_ctrl_d;
            grp1_q    <= grp1_d;
            grp2_q    <= grp2_d;
            stat_q    <= stat_d;
        end
    end

    // read mux, unmapped reads zero
    assign rd_mux = (addr_i == OFS_PIN_EDGE) ? pin_edge_q :
                    (addr_i == OFS_CTRL_A)   ? ctrl_a_q   :
                    (addr_i == OFS_CTRL_B)   ? ctrl_b_q   :
                    (addr_i == OFS_CTRL_C)   ? ctrl_c_q   :
                    (addr_i == OFS_CT_CTRL)  ? ct_ctrl_q  :
                    (addr_i == OFS_FILT_LOW) ? filt_low_q :
                    (addr_i == OFS_GRP1)     ? grp1_q     :
                    (addr_i == OFS_GRP2)     ? grp2_q     :
                    (addr_i == OFS_IRQ_STAT) ? stat_q     :
                    (addr_i == OFS_IRQ_MASK) ? mask_q     : RST_ZERO;

    // read data register, zero when no read
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            rdata_q <= RST_ZERO;
        end else if (ce_i) begin
            rdata_q <= rd_i ? rd_mux : RST_ZERO;
        end
    end
    assign rdata_o = rdata_q;
    assign irq_o   = |(stat_q & mask_q);

    // assertions
    a_global_gate: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        !ctrl_a_q[BIT_GIE] |-> !vec_req_o) else $error("vector with global off");
    a_take_clears_gie: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        take |=> !ctrl_a_q[BIT_GIE]) else $error("global enable kept");
    a_stack_full_hold: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        stack_full_i |-> !vec_req_o) else $error("vector while stack full");
    a_enable_gate: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (ctrl_a_q[BIT_PIN_F] && !ctrl_a_q[BIT_PIN_E] && ce_i && !we_a && !take)
        |=> ctrl_a_q[BIT_PIN_F]) else $error("flag lost");
    a_pin_flag_set: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        pin_hit |=> ctrl_a_q[BIT_PIN_F]) else $error("pin flag not set");
    a_flt_flag_set: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        flt_hit |=> ctrl_a_q[BIT_FLT_F]) else $error("filtered flag not set");
    a_pin_off_quiet: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (pin_edge_q[1:0] == EDGE_OFF) |-> !pin_hit) else $error("edge while off");
    a_ctrl_c_zero: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (ctrl_c_q & ~MASK_CTRL_C) == RST_ZERO) else $error("absent bit set");
    a_read_timing: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (ce_i && rd_i && addr_i == OFS_CTRL_C) ##1 ce_i |-> rdata_o[3:1] == 3'h0)
        else $error("absent bits read nonzero");
    a_prio_pin: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (vec_req_o && pend[VEC_PIN]) |-> vec_num_o == VEC_PIN) else $error("priority");
    a_reset_clear: assert property (@(posedge mclk_i)
        !rst_n_i |=> ctrl_a_q == RST_ZERO) else $error("reset value");
    c_vector_taken: cover property (@(posedge mclk_i) disable iff (!rst_n_i) take);
    c_stack_block: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
        stack_full_i && any_pend && ctrl_a_q[BIT_GIE]);
    c_irq_raised: cover property (@(posedge mclk_i) disable iff (!rst_n_i) irq_o);
endmodule : mcu_interrupt_control
`default_nettype wire

// [hw/prio_select.sv]
`default_nettype none
module prio_select
    import irq_ctrl_pkg::*;
#(
    parameter int N = 8
) (
    input  wire logic [N-1:0] req_i,   // pending enabled requests
    output logic              any_o,   // at least one pending
    output logic [2:0]        vec_o    // lowest index wins
);
    // fixed priority, index 0 highest
    always_comb begin
        vec_o = 3'h0;
        for (int i = N - 1; i >= 0; i--) begin
            if (req_i[i]) begin
                vec_o = 3'(i);
            end
        end
    end
    assign any_o = |req_i;
endmodule : prio_select
`default_nettype wire

// [include/irq_ctrl_pkg.sv]
`default_nettype none
package irq_ctrl_pkg;
    // register offsets on the plain register port
    localparam logic [3:0] OFS_PIN_EDGE   = 4'h0; // pin_edge_select
    localparam logic [3:0] OFS_CTRL_A     = 4'h1; // primary_irq_ctrl_a
    localparam logic [3:0] OFS_CTRL_B     = 4'h2; // primary_irq_ctrl_b
    localparam logic [3:0] OFS_CTRL_C     = 4'h3; // primary_irq_ctrl_c
    localparam logic [3:0] OFS_CT_CTRL    = 4'h4; // compact_timer_irq_ctrl
    localparam logic [3:0] OFS_FILT_LOW   = 4'h5; // filter_low_level_and_edge
    localparam logic [3:0] OFS_GRP1       = 4'h6; // group 1 summary sources
    localparam logic [3:0] OFS_GRP2       = 4'h7; // group 2 summary sources
    localparam logic [3:0] OFS_IRQ_STAT   = 4'h8; // sticky status: vector taken, pin edge, filtered edge, stack refusal
    localparam logic [3:0] OFS_IRQ_MASK   = 4'h9; // mask for status
    // writable bit masks
    localparam logic [7:0] MASK_PIN_EDGE  = 8'h03;
    localparam logic [7:0] MASK_CTRL_A    = 8'h7f;
    localparam logic [7:0] MASK_CTRL_B    = 8'hff;
    localparam logic [7:0] MASK_CTRL_C    = 8'h11;
    localparam logic [7:0] MASK_GRP       = 8'h33;
    localparam logic [7:0] MASK_FILT_LOW  = 8'hdf;
    localparam logic [7:0] MASK_STAT      = 8'h0f;
    // reset values
    localparam logic [7:0] RST_ZERO       = 8'h00;
    localparam logic [7:0] RST_FILT_LOW   = 8'h0a;
    // field positions in primary_irq_ctrl_a
    localparam int BIT_GIE   = 0;
    localparam int BIT_PIN_E = 1;
    localparam int BIT_SER_E = 2;
    localparam int BIT_FLT_E = 3;
    localparam int BIT_PIN_F = 4;
    localparam int BIT_SER_F = 5;
    localparam int BIT_FLT_F = 6;
    // primary_irq_ctrl_b / c
    localparam int BIT_GRP_E0 = 0;
    localparam int BIT_TICK0_E = 3;
    localparam int BIT_GRP_F0 = 4;
    localparam int BIT_TICK0_F = 7;
    localparam int BIT_TICK1_E = 0;
    localparam int BIT_TICK1_F = 4;
    // group register layout: enables 1..0, flags 5..4
    localparam int BIT_SUB_E0 = 0;
    localparam int BIT_SUB_F0 = 4;
    // filtered input edge field position
    localparam int BIT_FLT_EDGE = 6;
    // edge codes
    localparam logic [1:0] EDGE_OFF  = 2'b00;
    localparam logic [1:0] EDGE_RISE = 2'b01;
    localparam logic [1:0] EDGE_FALL = 2'b10;
    localparam logic [1:0] EDGE_BOTH = 2'b11;
    // vector numbers in priority order
    localparam int NUM_VEC = 8;
    localparam logic [2:0] VEC_PIN   = 3'h0;
    localparam logic [2:0] VEC_FLT   = 3'h1;
    localparam logic [2:0] VEC_SER   = 3'h2;
    localparam logic [2:0] VEC_GRP0  = 3'h3;
    localparam logic [2:0] VEC_GRP1  = 3'h4;
    localparam logic [2:0] VEC_GRP2  = 3'h5;
    localparam logic [2:0] VEC_TICK0 = 3'h6;
    localparam logic [2:0] VEC_TICK1 = 3'h7;
endpackage : irq_ctrl_pkg
`default_nettype wire

// [verification/core_model.sv]
`default_nettype none
module core_model
    import irq_ctrl_pkg::*;
(
    input  wire logic       mclk_i,     // system clock
    input  wire logic       rst_n_i,    // sync reset, active low
    input  wire logic       vec_req_i,  // vector request from the controller
    input  wire logic [2:0] vec_num_i,  // requested vector number
    input  wire logic [3:0] delay_i,    // cycles to hold off before taking
    output logic            vec_ack_o,  // vector taken this cycle
    output logic      [2:0] last_num_o, // last vector taken
    output logic      [7:0] n_taken_o   // count of vectors taken
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [3:0] wait_q; // cycles the current request has waited

    // take the vector once the request has waited long enough
    assign vec_ack_o = vec_req_i && (wait_q >= delay_i);

    // count the wait and log every vector taken
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            wait_q     <= 4'h0;
            last_num_o <= 3'h0;
            n_taken_o  <= 8'h00;
        end else begin
            wait_q <= (vec_req_i && !vec_ack_o) ? wait_q + 4'h1 : 4'h0;
            if (vec_req_i && vec_ack_o) begin
                last_num_o <= vec_num_i;
                n_taken_o  <= n_taken_o + 8'h01;
            end
        end
    end
endmodule : core_model
`default_nettype wire

// [verification/test_mcu_interrupt_control.sv]
`default_nettype none
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin failures++; \
    $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module test_mcu_interrupt_control
    import irq_ctrl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic       mclk_i, rst_n_i, wr_i, rd_i, int_pin_i, fpin, stack_full_i;
    logic [3:0] addr_i, delay;
    logic [7:0] wdata_i, rdata_o, n_taken;
    logic [9:0] src;
    logic       vec_req_o, vec_ack, irq_o;
    logic [2:0] vec_num_o, last_num;
    int         failures, n_compared;
    // address, written value, read-back value, reset value
    logic [3:0] t_a[10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9, 4'ha};
    logic [7:0] t_w[10] = '{8'hff, 8'hfe, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};
    logic [7:0] t_e[10] = '{8'h03, 8'h7e, 8'hff, 8'h11, 8'h33, 8'hdf, 8'h33, 8'h33, 8'h0f, 8'h00};
    logic [7:0] t_r[10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0a, 8'h00, 8'h00, 8'h00, 8'h00};

    mcu_interrupt_control uut (
        .mclk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(1'b1), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .int_pin_i(int_pin_i),
        .filtered_input_pin_i(fpin), .serial_req_i(src[0]), .tick0_req_i(src[1]),
        .tick1_req_i(src[2]), .ct_cmp_a_req_i(src[3]), .ct_cmp_p_req_i(src[4]),
        .grp1_req_i(src[6:5]), .grp2_req_i(src[9:7]), .stack_full_i(stack_full_i),
        .vec_ack_i(vec_ack), .vec_req_o(vec_req_o), .vec_num_o(vec_num_o), .irq_o(irq_o));

    core_model core (
        .mclk_i(mclk_i), .rst_n_i(rst_n_i), .vec_req_i(vec_req_o), .vec_num_i(vec_num_o),
        .delay_i(delay), .vec_ack_o(vec_ack), .last_num_o(last_num), .n_taken_o(n_taken));

    // free-running 50 MHz clock
    initial begin
        mclk_i = 1'b0;
        forever #10 mclk_i = ~mclk_i;
    end

    // one-cycle register write
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask : wr

    // one-cycle register read, data compared in the cycle after the strobe
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
        @(posedge mclk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1 `CHK(rdata_o, e)
    endtask : rd_chk

    // one-cycle pulse on the request sources
    task automatic pulse(input logic [9:0] v);
        @(posedge mclk_i);
        src <= v;
        @(posedge mclk_i);
        src <= 10'h000;
    endtask : pulse

    // drive one pin to a level and let the synchroniser settle
    task automatic pin_to(input int which, input logic lvl);
        @(posedge mclk_i);
        if (which == 0) int_pin_i <= lvl;
        else fpin <= lvl;
        repeat (8) @(posedge mclk_i);
    endtask : pin_to

    // rising then falling edge on a pin under one edge code
    task automatic edge_case(input int which, input logic [1:0] code);
        logic [7:0] fbit;
        fbit = (which == 0) ? 8'h10 : 8'h40;
        if (which == 0) wr(OFS_PIN_EDGE, {6'h00, code});
        else wr(OFS_FILT_LOW, {code, 6'h0a});
        pin_to(which, 1'b1);
        rd_chk(OFS_CTRL_A, code[0] ? fbit : 8'h00);
        wr(OFS_CTRL_A, 8'h00);
        pin_to(which, 1'b0);
        rd_chk(OFS_CTRL_A, code[1] ? fbit : 8'h00);
        wr(OFS_CTRL_A, 8'h00);
        if (which == 0) wr(OFS_PIN_EDGE, 8'h00);
        else wr(OFS_FILT_LOW, 8'h0a);
    endtask : edge_case

    // counts, verdict and end of run
    task automatic print_verdict();
        $display("compared %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : print_verdict

    // hang guard, far beyond the length of the sequence
    initial begin
        #(40000 * 20);
        failures++;
        print_verdict();
    end

    // main sequence
    initial begin
        {rst_n_i, wr_i, rd_i, int_pin_i, fpin, stack_full_i} = 6'h00;
        {addr_i, wdata_i, src, delay} = '0;
        failures = 0;
        n_compared = 0;
        repeat (12) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        for (int i = 0; i < 10; i++) rd_chk(t_a[i], t_r[i]);
        for (int i = 0; i < 10; i++) wr(t_a[i], t_w[i]);
        for (int i = 0; i < 10; i++) rd_chk(t_a[i], t_e[i]);
        for (int i = 0; i < 10; i++) wr(t_a[9 - i], t_r[9 - i]);
        for (int i = 0; i < 8; i++) edge_case(i / 4, i[1:0]);
        rd_chk(OFS_IRQ_STAT, 8'h06);
        // a recorded flag with global enable low requests nothing
        wr(OFS_CTRL_A, 8'h04);
        pulse(10'h001);
        rd_chk(OFS_CTRL_A, 8'h24);
        `CHK(vec_req_o, 1'b0)
        wr(OFS_IRQ_MASK, 8'h01);
        wr(OFS_CTRL_A, 8'h25);
        rd_chk(OFS_CTRL_A, 8'h04);
        `CHK(last_num, VEC_SER)
        `CHK(irq_o, 1'b1)
        rd_chk(OFS_IRQ_STAT, 8'h01);
        `CHK(irq_o, 1'b0)
        // two sources at once, stack full, slow core
        stack_full_i <= 1'b1;
        delay <= 4'h3;
        wr(OFS_CTRL_B, 8'h08);
        pulse(10'h003);
        wr(OFS_CTRL_A, 8'h25);
        repeat (5) @(posedge mclk_i);
        `CHK(vec_req_o, 1'b0)
        `CHK(n_taken, 8'h01)
        rd_chk(OFS_IRQ_STAT, 8'h08);
        stack_full_i <= 1'b0;
        repeat (8) @(posedge mclk_i);
        `CHK(last_num, VEC_SER)
        `CHK(n_taken, 8'h02)
        rd_chk(OFS_CTRL_B, 8'h88);
        wr(OFS_CTRL_A, 8'h05);
        repeat (8) @(posedge mclk_i);
        `CHK(last_num, VEC_TICK0)
        rd_chk(OFS_CTRL_B, 8'h08);
        // group summary flags and tick 1
        wr(OFS_CTRL_A, 8'h00);
        wr(OFS_CT_CTRL, 8'h02);
        wr(OFS_GRP1, 8'h02);
        wr(OFS_CTRL_B, 8'h01);
        pulse(10'h24c);
        rd_chk(OFS_CT_CTRL, 8'h22);
        rd_chk(OFS_GRP1, 8'h22);
        rd_chk(OFS_CTRL_B, 8'h71);
        rd_chk(OFS_CTRL_C, 8'h10);
        print_verdict();
    end
endmodule : test_mcu_interrupt_control
`default_nettype wire
